/* File: core/iod_pkg.sv */
// iod_pkg: shared widths, field layouts, command decode constants and carriers
// assumes the processor word and order layouts are set by the parameters here
package iod_pkg;
	localparam int IOD_ADDR_W     = 15;            // memory address width
	localparam int IOD_ORDER_W    = 48;            // order register width
	localparam int IOD_CMD_W      = 4;             // command field width
	localparam int IOD_CMD_LSB    = 0;             // command field position
	localparam int IOD_IDX_W      = 3;             // index register select width
	localparam int IOD_NSYS       = 16;            // one select line per command code
	localparam logic [3:0] IOD_CMD_TAPE_LO = 4'h8; // tape codes 1000..1111
	localparam logic [3:0] IOD_CMD_ILLEGAL_MASK_LO = 4'h0; // code 0000 never legal
	localparam logic [IOD_ADDR_W-1:0] IOD_ADDR_RST = 15'h0000;
	localparam int IOD_REPLY_WAIT = 16;            // cycles to wait for a controller answer
	localparam logic [4:0] IOD_REPLY_WAIT_C = 5'h10;

	// refusal causes kept for later skip tests
	typedef struct packed {
		logic illegal;   // no system answers to this code
		logic refused;   // system declined the order
		logic timeout;   // system never answered
	} iod_cause_t;

	// instruction as presented by the sequencer
	typedef struct packed {
		logic                  addr_present;
		logic                  index_sel;
		logic [IOD_IDX_W-1:0]  index_num;
		logic [IOD_ADDR_W-1:0] addr;
	} iod_instr_t;

	typedef enum logic [1:0] {
		IOD_IDLE  = 2'b00,
		IOD_QUERY = 2'b01,
		IOD_HAND  = 2'b10,
		IOD_DONE  = 2'b11
	} iod_state_t;
endpackage : iod_pkg

/* File: core/iod_dispatch.sv */
// iod_dispatch: executes the transfer-control-to-io instruction
// assumes the sequencer holds start for one cycle and waits for done before the next fetch
`timescale 1ns/1ps
// What this block does
// - the transfer-control-to-io instruction is indexable and starts the order held
// - order register fields go to the addressed io system controller
// - a present address goes into the io memory address register
// - index select 1 adds index register contents; 0 loads address unchanged
// - command field decoded; selected system is asked whether it accepts
// - on acceptance hand over order and address, then skip next instruction
// - refusal or illegal command falls through to next instruction
// - refusal cause stays available for later skip tests
// - command codes 1000 through 1111 select magnetic tape systems
// - tape stop, release, resume accepted with blank address field
module iod_dispatch
	import iod_pkg::*;
#(
	parameter int REPLY_WAIT = IOD_REPLY_WAIT  // cycles a controller has to answer
)
(
	input  wire logic                      clock,
	input  wire logic                      rst_n,
	input  wire logic                      start,
	input  wire iod_instr_t                instr,
	input  wire logic [IOD_ORDER_W-1:0]    order_reg,
	input  wire logic [IOD_ADDR_W-1:0]     index_value,
	input  wire logic [IOD_NSYS-1:0]       sys_present,
	input  wire logic                      sys_reply,
	input  wire logic                      sys_accept,
	input  wire logic                      cause_clear,
	output logic [IOD_IDX_W-1:0]           index_num,
	output logic [IOD_NSYS-1:0]            sys_query,
	output logic [IOD_NSYS-1:0]            sys_load,
	output logic [IOD_ORDER_W-1:0]         sys_order,
	output logic [IOD_ADDR_W-1:0]          io_memory_address_register,
	output logic                           tape_selected,
	output logic                           done,
	output logic                           skip,
	output iod_cause_t                     cause
);
	// decode the command field into one-hot select lines
	function automatic logic [IOD_NSYS-1:0] cmd_select(input logic [IOD_CMD_W-1:0] c);
		cmd_select = IOD_NSYS'(1) << c;
	endfunction : cmd_select

	iod_state_t                 state;
	iod_state_t                 next_state;
	logic [IOD_CMD_W-1:0]       cmd;
	logic [IOD_CMD_W-1:0]       next_cmd;
	logic [4:0]                 wait_cnt;
	logic [4:0]                 next_wait_cnt;
	logic [IOD_NSYS-1:0]        next_sys_query;
	logic [IOD_NSYS-1:0]        next_sys_load;
	logic [IOD_ORDER_W-1:0]     next_sys_order;
	logic [IOD_ADDR_W-1:0]      next_ioma;
	logic [IOD_IDX_W-1:0]       next_index_num;
	logic                       next_tape;
	logic                       next_done;
	logic                       next_skip;
	iod_cause_t                 next_cause;
	logic [IOD_CMD_W-1:0]       order_cmd;
	logic                       take;
	logic                       illegal_code;
	logic                       got_accept;
	logic                       got_refuse;
	logic                       got_timeout;

	// last query cycle before the answer window closes
	localparam logic [4:0] REPLY_LAST = 5'(REPLY_WAIT - 1);

	assign order_cmd = order_reg[IOD_CMD_LSB +: IOD_CMD_W];

	// instruction taken, code legality and the three controller outcomes
	assign take         = (state == IOD_IDLE) && start;
	assign illegal_code = (order_cmd == IOD_CMD_ILLEGAL_MASK_LO)
		|| !sys_present[order_cmd];
	assign got_accept   = (state == IOD_QUERY) && sys_reply && sys_accept;
	assign got_refuse   = (state == IOD_QUERY) && sys_reply && !sys_accept;
	assign got_timeout  = (state == IOD_QUERY) && !sys_reply && (wait_cnt == REPLY_LAST);

	// sequencer: idle, wait for the controller, hand over, report
	always_comb begin
		next_state    = state;
		next_cmd      = cmd;
		next_wait_cnt = wait_cnt;
		unique case (state)
			IOD_IDLE: begin
				if (take) begin
					next_cmd      = order_cmd;
					next_wait_cnt = '0;
					next_state    = illegal_code ? IOD_DONE : IOD_QUERY;
				end
			end
			IOD_QUERY: begin
				next_wait_cnt = wait_cnt + 5'h01;
				if (got_accept) begin
					next_state = IOD_HAND;
				end else if (got_refuse || got_timeout) begin
					next_state = IOD_DONE;
				end
			end
			IOD_HAND: begin
				next_state = IOD_DONE;
			end
			IOD_DONE: begin
				next_state = IOD_IDLE;
			end
		endcase
	end

	// sequencer registers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state    <= IOD_IDLE;
			cmd      <= '0;
			wait_cnt <= '0;
		end else begin
			state    <= next_state;
			cmd      <= next_cmd;
			wait_cnt <= next_wait_cnt;
		end
	end

	// starting address, index select and tape decode, all taken with start
	always_comb begin
		next_ioma      = io_memory_address_register;
		next_index_num = index_num;
		next_tape      = tape_selected;
		if (take) begin
			next_index_num = instr.index_num;
			next_tape      = order_cmd >= IOD_CMD_TAPE_LO;
			if (instr.addr_present) begin
				next_ioma = instr.index_sel ?
					IOD_ADDR_W'(instr.addr + index_value) : instr.addr;
			end
		end
	end

	// address registers; a blank address leaves the old start address
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			io_memory_address_register <= IOD_ADDR_RST;
			index_num                  <= '0;
			tape_selected              <= 1'b0;
		end else begin
			io_memory_address_register <= next_ioma;
			index_num                  <= next_index_num;
			tape_selected              <= next_tape;
		end
	end

	// controller lines: query level, load pulse and the handed order
	always_comb begin
		next_sys_query = sys_query;
		next_sys_load  = '0;
		next_sys_order = sys_order;
		if (take && !illegal_code) begin
			next_sys_query = cmd_select(order_cmd);
		end
		if (got_accept) begin
			next_sys_order = order_reg;
			next_sys_load  = cmd_select(cmd);
		end
		if (got_accept || got_refuse || got_timeout) begin
			next_sys_query = '0;
		end
	end

	// controller line registers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sys_query <= '0;
			sys_load  <= '0;
			sys_order <= '0;
		end else begin
			sys_query <= next_sys_query;
			sys_load  <= next_sys_load;
			sys_order <= next_sys_order;
		end
	end

	// outcome: done pulse, skip level and kept cause; a new cause beats a clear
	always_comb begin
		next_done  = state == IOD_DONE;
		next_skip  = skip;
		next_cause = cause;
		if (cause_clear) begin
			next_cause = '0;
		end
		if (take) begin
			next_skip = 1'b0;
		end
		if (state == IOD_HAND) begin
			next_skip = 1'b1;
		end
		if (take && illegal_code) begin
			next_cause = '{illegal: 1'b1, refused: 1'b0, timeout: 1'b0};
		end
		if (got_accept) begin
			next_cause = '0;
		end
		if (got_refuse) begin
			next_cause = '{illegal: 1'b0, refused: 1'b1, timeout: 1'b0};
		end
		if (got_timeout) begin
			next_cause = '{illegal: 1'b0, refused: 1'b0, timeout: 1'b1};
		end
	end

	// outcome registers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			done  <= 1'b0;
			skip  <= 1'b0;
			cause <= '0;
		end else begin
			done  <= next_done;
			skip  <= next_skip;
			cause <= next_cause;
		end
	end
endmodule : iod_dispatch

/* File: dv/iod_dispatch_properties.sv */
// iod_dispatch_properties: port timing checks for the io order dispatch block
// assumes order_reg stays steady through each instruction
`timescale 1ns/1ps
module iod_dispatch_properties
	import iod_pkg::*;
(
	input wire logic                   clock,
	input wire logic                   rst_n,
	input wire logic [IOD_ORDER_W-1:0] order_reg,
	input wire logic                   sys_reply,
	input wire logic                   sys_accept,
	input wire logic [IOD_NSYS-1:0]    sys_query,
	input wire logic [IOD_NSYS-1:0]    sys_load,
	input wire logic [IOD_ORDER_W-1:0] sys_order,
	input wire logic                   done,
	input wire logic                   skip,
	input wire iod_cause_t             cause
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// acceptance handshake then handover, skip and done
	sequence s_ack;
		(|sys_query) && sys_reply && sys_accept;
	endsequence
	sequence s_hand;
		sys_load == $past(sys_query) ##1 skip ##1 done;
	endsequence
	a_accept_hand: assert property (s_ack |=> s_hand)
		else $error("accepted order not handed over in time");
	a_refuse_fall: assert property ((|sys_query) && sys_reply && !sys_accept
		|=> ##1 done && !skip && cause.refused)
		else $error("refused order did not fall through");
	a_order_hand: assert property ((|sys_load) |-> sys_order == $past(order_reg))
		else $error("handed order differs from order register");
	a_query_code: assert property ((|sys_query) |-> sys_query == (16'h0001 << order_reg[3:0]))
		else $error("query line does not match command code");
	a_cause_kept: assert property (done && !skip |-> cause != 3'h0)
		else $error("fall through without a kept cause");
	a_accept_clear: assert property (done && skip |-> cause == 3'h0)
		else $error("cause left set after acceptance");
	a_done_single: assert property (done |=> !done)
		else $error("done longer than one cycle");
	a_load_single: assert property ((|sys_load) |=> !(|sys_load) && skip)
		else $error("load pulse not followed by skip");
	a_query_wait: assert property ((|sys_query) |-> ##[0:17] sys_query == 16'h0000)
		else $error("query outlived reply wait");
endmodule : iod_dispatch_properties
bind iod_dispatch iod_dispatch_properties checker_i (.*);

/* File: dv/iod_ctrl_model.sv */
// iod_ctrl_model: io system controller that answers the query lines
// assumes the bench sets delay and accept before each start
`timescale 1ns/1ps
module iod_ctrl_model
	import iod_pkg::*;
(
	input  wire logic                clock,
	input  wire logic [IOD_NSYS-1:0] sys_query,
	input  wire logic [4:0]          dly,
	input  wire logic                acc,
	output logic                     sys_reply,
	output logic                     sys_accept
);
	logic [4:0] cnt;
	// count query cycles, answer after dly of them
	always_ff @(posedge clock) cnt <= (|sys_query) ? cnt + 5'h01 : 5'h00;
	assign sys_reply  = (|sys_query) && cnt == dly;
	assign sys_accept = sys_reply ? acc : ~acc;
endmodule : iod_ctrl_model

/* File: dv/iod_dispatch_test.sv */
// iod_dispatch_test: table driven bench for the io order dispatch block
// assumes one controller model answers every query
`timescale 1ns/1ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
	$display("unexpected %s exp %h got %h", n, e, a); end end
module iod_dispatch_test;
	import iod_pkg::*;
	typedef struct packed {
		logic [3:0]  cmd;
		logic        ap;
		logic        is;
		logic [14:0] addr;
		logic        acc;
		logic [4:0]  dly;
		logic        eskip;
		logic [2:0]  ecause;
	} iod_row_t;
	logic clock = 0, rst_n = 0, start = 0, cause_clear = 0, acc = 0, sys_reply, sys_accept;
	logic tape_selected, done, skip;
	iod_instr_t  instr = '0;
	logic [47:0] order_reg = '0, sys_order;
	logic [15:0] sys_present = 16'hFF0E, sys_query, sys_load;
	logic [4:0]  dly = 5'h00;
	logic [14:0] index_value, ioma, eioma = 15'h0000;
	logic [2:0]  index_num;
	iod_cause_t  cause;
	int          total_checks = 0, mismatches = 0;
	iod_row_t    rows [8];
	// index register file stand-in and clock
	assign index_value = {4'h0, instr.index_num, 8'h00};
	always #4 clock = ~clock;
	iod_dispatch uut (.clock, .rst_n, .start, .instr, .order_reg, .index_value, .sys_present,
		.sys_reply, .sys_accept, .cause_clear, .index_num, .sys_query, .sys_load, .sys_order,
		.io_memory_address_register(ioma), .tape_selected, .done, .skip, .cause);
	iod_ctrl_model partner (.clock, .sys_query, .dly, .acc, .sys_reply, .sys_accept);
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	// issue one instruction in the same cycle as its order and wait for done
	task automatic run(iod_row_t r);
		int n;
		@(negedge clock);
		instr = '{r.ap, r.is, r.cmd[2:0], r.addr};
		order_reg = {44'h123456789AB, r.cmd};
		acc = r.acc;
		dly = r.dly;
		start = 1;
		@(negedge clock);
		start = 0;
		for (n = 0; n < 40 && done !== 1'b1; n++) @(negedge clock);
		if (done !== 1'b1) begin mismatches++; give_verdict(); end
	endtask : run
	initial begin
		rows[0] = '{4'h8, 1'b1, 1'b0, 15'h0200, 1'b1, 5'h00, 1'b1, 3'h0};
		rows[1] = '{4'hF, 1'b1, 1'b1, 15'h7FF0, 1'b1, 5'h03, 1'b1, 3'h0};
		rows[2] = '{4'h9, 1'b0, 1'b0, 15'h0000, 1'b1, 5'h01, 1'b1, 3'h0};
		rows[3] = '{4'h1, 1'b1, 1'b0, 15'h0400, 1'b0, 5'h02, 1'b0, 3'h2};
		rows[4] = '{4'h0, 1'b0, 1'b0, 15'h0000, 1'b1, 5'h00, 1'b0, 3'h4};
		rows[5] = '{4'h5, 1'b0, 1'b0, 15'h0000, 1'b1, 5'h00, 1'b0, 3'h4};
		rows[6] = '{4'h2, 1'b0, 1'b0, 15'h0000, 1'b1, 5'h1F, 1'b0, 3'h1};
		rows[7] = '{4'h3, 1'b0, 1'b0, 15'h0000, 1'b1, 5'h00, 1'b1, 3'h0};
		repeat (16) @(negedge clock);
		rst_n = 1;
		`CHK("cause", 3'h0, cause)
		foreach (rows[i]) begin
			run(rows[i]);
			if (rows[i].ap) eioma = rows[i].addr + (rows[i].is ? index_value : 15'h0000);
			`CHK("skip", rows[i].eskip, skip)
			`CHK("cause", rows[i].ecause, cause)
			`CHK("ioma", eioma, ioma)
			`CHK("tape", rows[i].cmd >= 4'h8, tape_selected)
			`CHK("index", rows[i].cmd[2:0], index_num)
		end
		// refusal then explicit clear of the kept cause
		run(rows[3]);
		cause_clear = 1;
		@(negedge clock);
		cause_clear = 0;
		`CHK("cleared", 3'h0, cause)
		// an illegal code in the same cycle as a clear keeps its cause
		order_reg = {44'h0, 4'h5};
		start = 1;
		cause_clear = 1;
		@(negedge clock);
		start = 0;
		cause_clear = 0;
		`CHK("set wins", 3'h4, cause)
		@(negedge clock);
		`CHK("illegal done", 1'b1, done)
		// reset in the middle of a query, then recover
		order_reg = {44'h0, 4'h2};
		dly = 5'h1F;
		start = 1;
		@(negedge clock);
		start = 0;
		repeat (4) @(negedge clock);
		rst_n = 0;
		@(negedge clock);
		rst_n = 1;
		`CHK("query", 16'h0000, sys_query)
		`CHK("reset cause", 3'h0, cause)
		`CHK("reset ioma", 15'h0000, ioma)
		run(rows[0]);
		`CHK("skip", 1'b1, skip)
		give_verdict();
	end
endmodule : iod_dispatch_test
